/* File: rtl/thermal_alert_pkg.sv */
/*
 * Thermal alert constants: pointers, fields, reset values, link states.
 * Assumes a 200 MHz ref_clk.
 */
package thermal_alert_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register pointer values
    localparam logic [2:0] ptr_temp    = 3'h0;
    localparam logic [2:0] ptr_config  = 3'h1;
    localparam logic [2:0] ptr_release = 3'h2;
    localparam logic [2:0] ptr_trip    = 3'h3;
    localparam logic [2:0] ptr_reset   = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration register fields
    localparam int cfg_shutdown = 0;
    localparam int cfg_mode     = 1;
    localparam int cfg_pol      = 2;
    localparam int cfg_fq_lo    = 3;
    localparam int cfg_fq_hi    = 4;
    localparam int cfg_width    = 5;
    localparam logic [4:0] config_reset = 5'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Threshold defaults in half-degree steps: 80 C and 75 C
    localparam logic [8:0] trip_reset    = 9'h0A0;
    localparam logic [8:0] release_reset = 9'h096;

    ////////////////////////////////////////////////////////////////////////////////
    // Consecutive fault counts per fault_count_select code
    localparam logic [2:0] fq_need_0 = 3'h1;
    localparam logic [2:0] fq_need_1 = 3'h2;
    localparam logic [2:0] fq_need_2 = 3'h4;
    localparam logic [2:0] fq_need_3 = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////
    // Link framing
    localparam logic [3:0] bits_per_byte = 4'h8;

    typedef enum logic [2:0] {
        st_idle     = 3'b000,
        st_addr     = 3'b001,
        st_addr_ack = 3'b010,
        st_rx       = 3'b011,
        st_rx_ack   = 3'b100,
        st_tx       = 3'b101,
        st_tx_ack   = 3'b110
    } link_state_t;

endpackage

/* File: rtl/reg_link_if.sv */
/*
 * Byte carrier from bus target to register file.
 * Assumes both ends on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

interface reg_link_if;
    logic       start;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_req;
    logic [7:0] tx_data;

    modport target (output start, output rx_valid, output rx_data, output tx_req,
                    input tx_data);
    modport regs   (input start, input rx_valid, input rx_data, input tx_req,
                    output tx_data);
endinterface

`default_nettype wire

/* File: rtl/twowire_target.sv */
/*
 * Two-wire bus target with framing, acknowledge and timeout.
 * Assumes raw pad levels, sampled far above bus rate.
 */
`timescale 1ns/1ps
`default_nettype none

module twowire_target #(
    parameter logic [6:0] dev_addr       = 7'h2A,           // Arbitrary bus address
    parameter int         timeout_cycles = 5_000_000
) (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    reg_link_if.target      lnk
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and one extra stage for edge detection
    logic scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic sda_s1_ff, sda_s2_ff, sda_d_ff;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff  <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff  <= 1'b1;
        end else begin
            scl_s1_ff <= scl_i;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff  <= scl_s2_ff;
            sda_s1_ff <= sda_i;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff  <= sda_s2_ff;
        end
    end

    logic scl_rise, scl_fall, start_c, stop_c;

    // Bus events from synchronised levels
    assign scl_rise = scl_s2_ff & ~scl_d_ff;
    assign scl_fall = ~scl_s2_ff & scl_d_ff;
    assign start_c  = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
    assign stop_c   = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Link state
    thermal_alert_pkg::link_state_t state_ff, nxt_state;
    logic [7:0]  sh_ff, nxt_sh;
    logic [3:0]  cnt_ff, nxt_cnt;
    logic        rw_ff, nxt_rw;
    logic        ack_ff, nxt_ack;
    logic        oe_ff, nxt_oe;
    logic        start_ff, nxt_start;
    logic        rxv_ff, nxt_rxv;
    logic [7:0]  rxd_ff, nxt_rxd;
    logic        txr_ff, nxt_txr;
    logic [31:0] to_ff, nxt_to;

    // Next state of the bit and byte sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_sh    = sh_ff;
        nxt_cnt   = cnt_ff;
        nxt_rw    = rw_ff;
        nxt_ack   = ack_ff;
        nxt_oe    = oe_ff;
        nxt_start = 1'b0;
        nxt_rxv   = 1'b0;
        nxt_rxd   = rxd_ff;
        nxt_txr   = 1'b0;
        nxt_to    = 32'h0000_0000;
        if (state_ff != thermal_alert_pkg::st_idle && !scl_s2_ff) begin
            nxt_to = to_ff + 32'h0000_0001;
        end
        if (start_c) begin
            nxt_state = thermal_alert_pkg::st_addr;  // Also a repeated start
            nxt_cnt   = 4'h0;
            nxt_oe    = 1'b0;
            nxt_start = 1'b1;
        end else if (stop_c || to_ff >= 32'(timeout_cycles)) begin
            nxt_state = thermal_alert_pkg::st_idle;
            nxt_oe    = 1'b0;
        end else begin
            case (state_ff)
                thermal_alert_pkg::st_addr, thermal_alert_pkg::st_rx: begin
                    if (scl_rise) begin
                        nxt_sh  = {sh_ff[6:0], sda_s2_ff};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    // Ninth clock follows eight data bits [R15]
                    if (scl_fall && cnt_ff == thermal_alert_pkg::bits_per_byte) begin
                        nxt_cnt = 4'h0;
                        if (state_ff == thermal_alert_pkg::st_rx) begin
                            nxt_rxv   = 1'b1;
                            nxt_rxd   = sh_ff;
                            nxt_oe    = 1'b1;               // Acknowledge low [R16]
                            nxt_state = thermal_alert_pkg::st_rx_ack;
                        end else if (sh_ff[7:1] == dev_addr) begin
                            nxt_oe    = 1'b1;               // [R16]
                            nxt_rw    = sh_ff[0];
                            nxt_txr   = sh_ff[0];
                            nxt_state = thermal_alert_pkg::st_addr_ack;
                        end else begin
                            nxt_state = thermal_alert_pkg::st_idle;
                        end
                    end
                end
                thermal_alert_pkg::st_addr_ack: begin
                    if (scl_fall) begin
                        if (rw_ff) begin
                            nxt_sh    = lnk.tx_data;
                            nxt_oe    = ~lnk.tx_data[7];
                            nxt_state = thermal_alert_pkg::st_tx;
                        end else begin
                            nxt_oe    = 1'b0;
                            nxt_state = thermal_alert_pkg::st_rx;
                        end
                    end
                end
                thermal_alert_pkg::st_rx_ack: begin
                    if (scl_fall) begin
                        nxt_oe    = 1'b0;
                        nxt_state = thermal_alert_pkg::st_rx;
                    end
                end
                thermal_alert_pkg::st_tx: begin
                    if (scl_rise) begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    if (scl_fall) begin
                        if (cnt_ff == thermal_alert_pkg::bits_per_byte) begin
                            nxt_cnt   = 4'h0;
                            nxt_oe    = 1'b0;               // Host owns ack slot [R18]
                            nxt_state = thermal_alert_pkg::st_tx_ack;
                        end else begin
                            nxt_sh = {sh_ff[6:0], 1'b0};
                            nxt_oe = ~sh_ff[6];
                        end
                    end
                end
                thermal_alert_pkg::st_tx_ack: begin
                    if (scl_rise) begin
                        nxt_ack = ~sda_s2_ff;
                        nxt_txr = ~sda_s2_ff;               // Next byte only on ack [R17]
                    end
                    if (scl_fall) begin
                        if (ack_ff) begin
                            nxt_sh    = lnk.tx_data;
                            nxt_oe    = ~lnk.tx_data[7];
                            nxt_state = thermal_alert_pkg::st_tx;
                        end else begin
                            nxt_state = thermal_alert_pkg::st_idle;   // [R18] [R20]
                        end
                    end
                end
                thermal_alert_pkg::st_idle: begin
                    nxt_oe = 1'b0;
                end
                default: begin
                    nxt_state = thermal_alert_pkg::st_idle;
                    nxt_oe    = 1'b0;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= thermal_alert_pkg::st_idle;
            sh_ff    <= 8'h00;
            cnt_ff   <= 4'h0;
            rw_ff    <= 1'b0;
            ack_ff   <= 1'b0;
            oe_ff    <= 1'b0;
            start_ff <= 1'b0;
            rxv_ff   <= 1'b0;
            rxd_ff   <= 8'h00;
            txr_ff   <= 1'b0;
            to_ff    <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            sh_ff    <= nxt_sh;
            cnt_ff   <= nxt_cnt;
            rw_ff    <= nxt_rw;
            ack_ff   <= nxt_ack;
            oe_ff    <= nxt_oe;
            start_ff <= nxt_start;
            rxv_ff   <= nxt_rxv;
            rxd_ff   <= nxt_rxd;
            txr_ff   <= nxt_txr;
            to_ff    <= nxt_to;
        end
    end

    // Open-drain data pin: only ever pulled low
    assign sda_o        = 1'b0;
    assign sda_oe       = oe_ff;
    assign lnk.start    = start_ff;
    assign lnk.rx_valid = rxv_ff;
    assign lnk.rx_data  = rxd_ff;
    assign lnk.tx_req   = txr_ff;

endmodule

`default_nettype wire

/* File: rtl/thermal_alert_output_control.sv */
/*
 * Thermal watchdog top: registers over the two-wire bus, threshold alert, shutdown.
 * Assumes a ref_clk converter pulsing conv_done and honouring conv_run.
 */
// Function
// R1 - Polarity bit sets alert active level
// R2 - Mode bit one latches, zero compares
// R3 - Comparator sets above trip, clears below release
// R4 - Comparator ignores reads and shutdown entry
// R5 - Interrupt fires on either crossing, cleared by read
// R6 - Host keeps trip above release
// R7 - Alert moves after enough consecutive faulty conversions
// R8 - Codes 0..3 need 1, 2, 4, 6 faults
// R9 - Fault code resets to zero
// R10 - Shutdown bit stops and resumes operation
// R11 - Shutdown halts conversions, bus stays usable
// R12 - Shutdown entry keeps comparator alert, clears interrupt
// R13 - Reset: normal, comparator, active low, 80/75 C, pointer zero
// R14 - Host starts only on idle bus
// R15 - Byte is eight data clocks plus ack clock
// R16 - Device acks low; host releases data then
// R17 - Second read byte only after host ack
// R18 - Final read slot is not-acknowledge, then stop
// R19 - Repeated start between pointer write and read
// R20 - One-byte temperature read allowed
// R21 - Only nine top temperature bits compared
// R22 - Alert pad low exactly when state and polarity say
// R23 - Interrupt arming alternates trip and release
`timescale 1ns/1ps
`default_nettype none

module thermal_alert_output_control #(
    parameter logic [6:0] dev_addr       = 7'h2A,           // Arbitrary bus address
    parameter int         timeout_cycles = 5_000_000
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             over_temp_alert_o,
    output logic             over_temp_alert_oe,
    output logic             conv_run,
    input  wire logic        conv_done,
    input  wire logic [10:0] conv_temp
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus target
    reg_link_if lnk ();

    twowire_target #(
        .dev_addr       (dev_addr),
        .timeout_cycles (timeout_cycles)
    ) u_target (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .sda_o   (sda_o),
        .sda_oe  (sda_oe),
        .lnk     (lnk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register file state
    logic [4:0]  config_ff, nxt_config;
    logic [8:0]  trip_ff, nxt_trip;
    logic [8:0]  release_ff, nxt_release;
    logic [2:0]  ptr_ff, nxt_ptr;
    logic [1:0]  wr_idx_ff, nxt_wr_idx;
    logic [1:0]  rd_idx_ff, nxt_rd_idx;
    logic [7:0]  msb_ff, nxt_msb;
    logic [15:0] shadow_ff, nxt_shadow;
    logic [7:0]  tx_ff, nxt_tx;
    logic [10:0] temp_ff, nxt_temp;
    logic [15:0] sel_word;
    logic        sd_enter;
    logic        reg_read;

    // Read word for the current pointer; temperature and thresholds left-aligned in 16 bits, config in the low bits of the first byte
    always_comb begin
        case (ptr_ff)
            thermal_alert_pkg::ptr_temp:    sel_word = {temp_ff, 5'h00};
            thermal_alert_pkg::ptr_config:  sel_word = {3'h0, config_ff, 8'h00};
            thermal_alert_pkg::ptr_release: sel_word = {release_ff, 7'h00};
            thermal_alert_pkg::ptr_trip:    sel_word = {trip_ff, 7'h00};
            default:                        sel_word = 16'h0000;
        endcase
    end

    // Pointer, write sequencing and read byte supply
    always_comb begin
        nxt_config  = config_ff;
        nxt_trip    = trip_ff;
        nxt_release = release_ff;
        nxt_ptr     = ptr_ff;
        nxt_wr_idx  = wr_idx_ff;
        nxt_rd_idx  = rd_idx_ff;
        nxt_msb     = msb_ff;
        nxt_shadow  = shadow_ff;
        nxt_tx      = tx_ff;
        sd_enter    = 1'b0;
        if (lnk.start) begin
            nxt_wr_idx = 2'h0;
            nxt_rd_idx = 2'h0;
        end
        // Registers stay writable in shutdown [R11]
        if (lnk.rx_valid) begin
            case (wr_idx_ff)
                2'h0: begin
                    nxt_ptr    = lnk.rx_data[2:0];
                    nxt_wr_idx = 2'h1;
                end
                2'h1: begin
                    nxt_msb    = lnk.rx_data;
                    nxt_wr_idx = 2'h2;
                    if (ptr_ff == thermal_alert_pkg::ptr_config) begin
                        nxt_config = lnk.rx_data[thermal_alert_pkg::cfg_width-1:0];
                        // Shutdown bit rising edge [R10]
                        sd_enter = lnk.rx_data[thermal_alert_pkg::cfg_shutdown] &
                                   ~config_ff[thermal_alert_pkg::cfg_shutdown];
                    end
                end
                2'h2: begin
                    nxt_wr_idx = 2'h3;
                    if (ptr_ff == thermal_alert_pkg::ptr_trip) begin
                        nxt_trip = {msb_ff, lnk.rx_data[7]};
                    end else if (ptr_ff == thermal_alert_pkg::ptr_release) begin
                        nxt_release = {msb_ff, lnk.rx_data[7]};
                    end
                end
                default: begin
                    nxt_wr_idx = wr_idx_ff;
                end
            endcase
        end
        // Snapshot keeps a read coherent [R17] [R20]
        if (lnk.tx_req) begin
            case (rd_idx_ff)
                2'h0: begin
                    nxt_shadow = sel_word;
                    nxt_tx     = sel_word[15:8];
                    nxt_rd_idx = 2'h1;
                end
                2'h1: begin
                    nxt_tx     = shadow_ff[7:0];
                    nxt_rd_idx = 2'h2;
                end
                default: begin
                    nxt_tx = 8'h00;
                end
            endcase
        end
    end

    // Any byte supplied to the host counts as a register read
    assign reg_read    = lnk.tx_req;
    assign lnk.tx_data = tx_ff;

    // Register file flops with power-on defaults
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            config_ff  <= thermal_alert_pkg::config_reset;     // [R9] [R13]
            trip_ff    <= thermal_alert_pkg::trip_reset;       // [R13]
            release_ff <= thermal_alert_pkg::release_reset;    // [R13]
            ptr_ff     <= thermal_alert_pkg::ptr_reset;        // [R13]
            wr_idx_ff  <= 2'h0;
            rd_idx_ff  <= 2'h0;
            msb_ff     <= 8'h00;
            shadow_ff  <= 16'h0000;
            tx_ff      <= 8'h00;
        end else begin
            config_ff  <= nxt_config;
            trip_ff    <= nxt_trip;
            release_ff <= nxt_release;
            ptr_ff     <= nxt_ptr;
            wr_idx_ff  <= nxt_wr_idx;
            rd_idx_ff  <= nxt_rd_idx;
            msb_ff     <= nxt_msb;
            shadow_ff  <= nxt_shadow;
            tx_ff      <= nxt_tx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog state
    logic       act_ff, nxt_act;
    logic       arm_low_ff, nxt_arm_low;
    logic [2:0] fcnt_ff, nxt_fcnt;
    logic [2:0] fcnt_inc;
    logic       alert_oe_ff, nxt_alert_oe;
    logic       run_ff, nxt_run;
    logic [2:0] need;
    logic [8:0] t9;
    logic       above, below, cond, int_mode, sd_now;

    // Required run length from the fault count field [R8]
    always_comb begin
        case (config_ff[thermal_alert_pkg::cfg_fq_hi:thermal_alert_pkg::cfg_fq_lo])
            2'h0:    need = thermal_alert_pkg::fq_need_0;
            2'h1:    need = thermal_alert_pkg::fq_need_1;
            2'h2:    need = thermal_alert_pkg::fq_need_2;
            default: need = thermal_alert_pkg::fq_need_3;
        endcase
    end

    // Signed compare of the nine top result bits [R21]
    assign t9       = conv_temp[10:2];
    assign above    = $signed(t9) > $signed(trip_ff);
    assign below    = $signed(t9) < $signed(release_ff);
    assign int_mode = config_ff[thermal_alert_pkg::cfg_mode];          // [R2]
    assign sd_now   = config_ff[thermal_alert_pkg::cfg_shutdown];
    assign cond     = arm_low_ff ? below : above;                      // [R23]
    assign fcnt_inc = fcnt_ff + 3'h1;

    // Alert decision; a fault event wins over a clear
    always_comb begin
        nxt_act     = act_ff;
        nxt_arm_low = arm_low_ff;
        nxt_fcnt    = fcnt_ff;
        nxt_temp    = temp_ff;
        // Clears act only in interrupt mode [R4] [R5] [R12]
        if (int_mode && (reg_read || sd_enter)) begin
            nxt_act = 1'b0;
        end
        // Conversions halted in shutdown [R11]
        if (conv_done && !sd_now) begin
            nxt_temp = conv_temp;
            if (cond) begin
                nxt_fcnt = fcnt_inc;
                // Enough consecutive faults change the alert [R7]
                if (fcnt_inc >= need) begin
                    nxt_fcnt    = 3'h0;
                    nxt_arm_low = ~arm_low_ff;                         // [R23]
                    if (int_mode) begin
                        nxt_act = 1'b1;                                // [R5]
                    end else begin
                        nxt_act = ~arm_low_ff;                         // [R3]
                    end
                end
            end else begin
                nxt_fcnt = 3'h0;                                       // [R7]
            end
        end
        // Pad pulled low when active xor polarity [R1] [R22]
        nxt_alert_oe = nxt_act ^ nxt_config[thermal_alert_pkg::cfg_pol];
        nxt_run      = ~nxt_config[thermal_alert_pkg::cfg_shutdown];  // [R10] [R11]
    end

    // Watchdog flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            act_ff      <= 1'b0;
            arm_low_ff  <= 1'b0;
            fcnt_ff     <= 3'h0;
            temp_ff     <= 11'h000;
            alert_oe_ff <= 1'b0;
            run_ff      <= 1'b1;                                       // [R13]
        end else begin
            act_ff      <= nxt_act;
            arm_low_ff  <= nxt_arm_low;
            fcnt_ff     <= nxt_fcnt;
            temp_ff     <= nxt_temp;
            alert_oe_ff <= nxt_alert_oe;
            run_ff      <= nxt_run;
        end
    end

    // Open-drain pad: only the enable moves
    assign over_temp_alert_o  = 1'b0;
    assign over_temp_alert_oe = alert_oe_ff;
    assign conv_run           = run_ff;

endmodule

`default_nettype wire

/* File: test/thermal_alert_assertions.sv */
/* Port checker for the alert block. Assumes host and converter act on ref_clk falls. */
`timescale 1ns/1ps
`default_nettype none
module thermal_alert_assertions (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic over_temp_alert_o,
    input wire logic over_temp_alert_oe,
    input wire logic conv_run,
    input wire logic conv_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_SDA_LOW_ONLY: assert property (sda_o == 1'b0)
        else $error("sda driven high");
    AST_ALERT_OPEN_DRAIN: assert property (over_temp_alert_o == 1'b0)
        else $error("alert driven high");
    AST_RESET_STATE: assert property ($rose(nrst) |-> !over_temp_alert_oe && conv_run && !sda_oe)
        else $error("bad state after reset");
    AST_DRIVE_AFTER_FALL: assert property ($changed(sda_oe) |-> !scl_i && $past(scl_i, 5))
        else $error("sda moved early");
    AST_SHUTDOWN_FREEZE: assert property (conv_done && !conv_run && scl_i |=> $stable(over_temp_alert_oe))
        else $error("shutdown leak");
    AST_ALERT_CAUSE: assert property ($changed(over_temp_alert_oe) |-> $past(conv_done) || !scl_i || !$past(scl_i, 6))
        else $error("alert moved without cause");
    AST_RUN_ON_SCL_LOW: assert property ($changed(conv_run) |-> !scl_i)
        else $error("run changed off a write");
    AST_SHUTDOWN_HOLDS: assert property ($fell(conv_run) |=> !conv_run [*8])
        else $error("shutdown did not hold");
    cover property ($rose(sda_oe));
    cover property ($fell(conv_run));
    cover property ($rose(over_temp_alert_oe));
endmodule
bind thermal_alert_output_control thermal_alert_assertions chk_i (.ref_clk(ref_clk), .nrst(nrst),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .over_temp_alert_o(over_temp_alert_o),
    .over_temp_alert_oe(over_temp_alert_oe), .conv_run(conv_run), .conv_done(conv_done));
`default_nettype wire

/* File: test/twowire_host_model.sv */
/* Two-wire host, 80 ns clock. Assumes SDA pull-up. */
`timescale 1ns/1ps
`default_nettype none
module twowire_host_model (
    output logic      scl,
    output logic      sda_h,
    input  wire logic sda_w
);
    // Bus rests released, clock still
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    // Start or repeated start
    task automatic start();
        sda_h = 1'b1;
        #20 scl = 1'b1;
        #20 sda_h = 0;
        #20 scl = 1'b0;
    endtask
    // Stop frees the bus
    task automatic stop();
        #20 sda_h = 1'b0;
        #20 scl = 1'b1;
        #20 sda_h = 1'b1;
    endtask
    // Nine clocks, ninth is the ack slot
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            #20 sda_h = d[i];
            #20 scl = 1'b1;
            q[i] = sda_w;
            #40 scl = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
/* Bench: host model on the bus, converter pulses from here. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk   = 1'b0;
    logic        nrst      = 1'b0;
    logic        conv_done = 1'b0;
    logic [10:0] conv_temp = 11'h000;
    logic        scl, sda_h, sda_oe, alert_oe, conv_run;
    logic [8:0]  q;
    logic [15:0] w;
    int          err_total = 0;
    int          n_checks  = 0;
    int          need[4]   = '{1, 2, 4, 6};
    wire logic   sda_w     = sda_h & ~sda_oe;
    always #2.5 ref_clk = ~ref_clk;
    twowire_host_model twowire_host_model_i (.scl(scl), .sda_h(sda_h), .sda_w(sda_w));
    thermal_alert_output_control #(.dev_addr(7'h2A), .timeout_cycles(2000))
        thermal_alert_output_control_i (.ref_clk(ref_clk), .nrst(nrst), .scl_i(scl),
        .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .over_temp_alert_o(),
        .over_temp_alert_oe(alert_oe), .conv_run(conv_run), .conv_done(conv_done),
        .conv_temp(conv_temp));
    task automatic chk(input logic ok);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Config write
    task automatic wr(input logic [7:0] d);
        twowire_host_model_i.start();
        twowire_host_model_i.xfer(9'h0A9, q);
        twowire_host_model_i.xfer(9'h003, q);
        twowire_host_model_i.xfer({d, 1'b1}, q);
        chk(q[0] === 1'b0);
        twowire_host_model_i.stop();
    endtask
    // Pointer write, restart, read
    task automatic rd(input logic [7:0] p, input logic two);
        twowire_host_model_i.start();
        twowire_host_model_i.xfer(9'h0A9, q);
        twowire_host_model_i.xfer({p, 1'b1}, q);
        twowire_host_model_i.start();
        twowire_host_model_i.xfer(9'h0AB, q);
        twowire_host_model_i.xfer({8'hFF, ~two}, q);
        w = {q[8:1], 8'h00};
        if (two) twowire_host_model_i.xfer(9'h1FF, q);
        if (two) w[7:0] = q[8:1];
        twowire_host_model_i.stop();
    endtask
    // One result
    task automatic conv(input logic [10:0] t);
        @(negedge ref_clk);
        conv_done = 1'b1;
        conv_temp = t;
        @(negedge ref_clk);
        conv_done = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic t_reset();
        chk(alert_oe === 1'b0 && conv_run === 1'b1);
        rd(8'h01, 1'b0);
        chk(w[15:8] === 8'h00);
        rd(8'h03, 1'b1);
        chk(w === 16'h5000);
        rd(8'h02, 1'b1);
        chk(w === 16'h4B00);
        $display("t_reset done");
    endtask
    task automatic t_comp();
        conv(11'h283);
        chk(alert_oe === 1'b0);
        conv(11'h284);
        rd(8'h00, 1'b0);
        chk(alert_oe === 1'b1 && w[15:8] === 8'h50);
        wr(8'h01);
        conv(11'h000);
        rd(8'h01, 1'b0);
        chk(alert_oe === 1'b1 && conv_run === 1'b0 && w[15:8] === 8'h01);
        wr(8'h00);
        conv(11'h258);
        chk(alert_oe === 1'b1);
        conv(11'h254);
        chk(alert_oe === 1'b0);
        $display("t_comp done");
    endtask
    task automatic t_queue();
        for (int c = 0; c < 4; c++) begin
            wr({3'b000, c[1:0], 3'b000});
            repeat (need[c] - 1) conv(11'h284);
            conv(11'h000);
            repeat (need[c] - 1) conv(11'h284);
            chk(alert_oe === 1'b0);
            conv(11'h284);
            chk(alert_oe === 1'b1);
            repeat (need[c]) conv(11'h000);
            chk(alert_oe === 1'b0);
        end
        $display("t_queue done");
    endtask
    task automatic t_int();
        wr(8'h02);
        conv(11'h284);
        chk(alert_oe === 1'b1);
        rd(8'h01, 1'b0);
        conv(11'h284);
        chk(alert_oe === 1'b0);
        conv(11'h000);
        chk(alert_oe === 1'b1);
        wr(8'h03);
        chk(alert_oe === 1'b0 && conv_run === 1'b0);
        wr(8'h04);
        chk(alert_oe === 1'b1 && conv_run === 1'b1);
        conv(11'h284);
        chk(alert_oe === 1'b0);
        $display("t_int done");
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_comp();
        t_queue();
        t_int();
        end_of_test();
    end
    // Hang guard
    initial begin
        #400000;
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
